// file: rtl/spcs_pkg.sv
// Constants and shared types for the serial port control and status block.
package spcs_pkg;
   // Bus word addresses of the data ports, the sub-address port and its data window.
   localparam logic [15:0] ADDR_RX_DATA  = 16'h0021;
   localparam logic [15:0] ADDR_TX_DATA  = 16'h0023;
   localparam logic [15:0] ADDR_SUB_SEL  = 16'h0038;
   localparam logic [15:0] ADDR_SUB_DATA = 16'h0039;
   localparam logic [15:0] SUB_RX_CTRL   = 16'h0000;
   localparam logic [15:0] SUB_TX_CTRL   = 16'h0001;
   // Field positions of the receive control and status register; B_EN and B_RDY serve the transmit one too.
   localparam int B_LOOP     = 15;
   localparam int B_JUST_LO  = 13;
   localparam int B_CSTP_HI  = 12;
   localparam int B_CSTP_LO  = 11;
   localparam int B_ALT      = 6;
   localparam int B_IRQM_LO  = 4;
   localparam int B_SERR     = 3;
   localparam int B_OVR      = 2;
   localparam int B_RDY      = 1;
   localparam int B_EN       = 0;
   // Stored read-write bits; flags and reserved bits are kept out of storage.
   localparam logic [15:0] RX_CTRL_RW_MASK = 16'hF8F1;
   localparam logic [15:0] TX_CTRL_RW_MASK = 16'h03F9;
   localparam logic [15:0] CTRL_RESET      = 16'h0000;
   localparam logic [15:0] UNMAPPED_READ   = 16'h0000;
   // Field codes.
   localparam logic [1:0] JUST_RIGHT_ZERO = 2'h0;
   localparam logic [1:0] JUST_RIGHT_SIGN = 2'h1;
   localparam logic [1:0] JUST_LEFT_ZERO  = 2'h2;
   localparam logic [1:0] CSTP_NO_DELAY   = 2'h2;
   localparam logic [1:0] CSTP_HALF_DELAY = 2'h3;
   localparam logic [1:0] IRQ_WORD        = 2'h0;
   localparam logic [1:0] IRQ_FRAME       = 2'h1;
   localparam logic [1:0] IRQ_FSYNC       = 2'h2;
   localparam logic [1:0] IRQ_SYNC_ERR    = 2'h3;
   // Bits of the configuration bundle passed to the link domain.
   localparam int CFG_RX_ON = 0;
   localparam int CFG_TX_ON = 1;
   localparam int CFG_LOOP  = 2;
   // Timing of the gated transfer clock.
   localparam int CLK_PERIOD_NS  = 4;
   localparam int XFER_PERIOD_NS = 32;
   localparam int XFER_HALF_CYC  = XFER_PERIOD_NS / 2 / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      SPCS_LS_IDLE  = 2'b01,
      SPCS_LS_SHIFT = 2'b10
   } spcs_lstate_t;

   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [15:0] wdata;
   } spcs_bus_req_t;
endpackage

// file: rtl/spcs_serial_port.sv
// Receive-side and transmit-side control and status registers with their serial datapath.
// Behaviour
// - Control bit 15 set selects digital loopback; clear selects normal pins.
// - Justify code 00 right/zero, 01 right/sign-extend, 10 left/zero-fill low bits.
// - Clock-stop field upper bit zero means continuous clocking, no clock stop.
// - Clock-stop 10 starts gated clock without half-cycle delay, edge per polarity.
// - Clock-stop 11 starts gated clock after half-cycle delay, edge per polarity.
// - Control bit 6 enables alternate framing mode.
// - Interrupt mode 00 follows word-ready; alternate framing adds end of frame.
// - Interrupt mode 01 fires at end of block or frame.
// - Interrupt mode 10 fires on each new receive frame sync.
// - Interrupt mode 11 fires whenever the sync error flag becomes set.
// - Bit 3 reads 1 after a receive frame sync error; software may write it.
// - Overrun bit 2 sets when data unread, buffer full and new word arrives.
// - Ready bit 1 reads 1 while received data waits in the data register.
// - Receive enable bit 0 clear holds the receiver disabled in reset.
// - Writing 1 to receive enable releases and enables the receiver.
// - Fields reset to zero; read-only fields ignore writes; read-write accept them.
// - Reserved bits have no storage and read as zero.
// - Writing 1 to a sync error bit forces the error condition.
// - Transmit enable bit 0 clear holds the transmitter disabled in reset.
// - Transmit ready bit 1 reads 1 when the transmit data register accepts a word.
module spcs_serial_port #(
   parameter int RX_BITS    = 8,
   parameter int XFER_HALF  = spcs_pkg::XFER_HALF_CYC
) (
   input  wire logic                    clk_i,
   input  wire logic                    nrst_i,
   input  wire spcs_pkg::spcs_bus_req_t bus_i,
   output logic [15:0]                  bus_rdata_o,
   output logic                         rx_irq_o,
   output logic                         xfer_clk_o,
   input  wire logic                    tx_clock_polarity_i,
   input  wire logic                    link_clk_i,
   input  wire logic                    dr_i,
   input  wire logic                    fs_i,
   output logic                         dx_o
);
   localparam logic [4:0] LAST_BIT = 5'(RX_BITS - 1);
   localparam logic [7:0] HALF_END = 8'(XFER_HALF - 1);

   typedef struct packed {
      logic [15:0]        rx_ctrl;
      logic [15:0]        tx_ctrl;
      logic [15:0]        sub_sel;
      logic [15:0]        rx_data;
      logic [RX_BITS-1:0] rx_buf;
      logic               buf_full;
      logic               rdy;
      logic               ovr;
      logic               serr;
      logic [15:0]        tx_data;
      logic               tx_req;
      logic [3:0]         ack_s;
      logic [3:0]         word_s;
      logic [3:0]         err_s;
      logic [3:0]         fss_s;
      logic [3:0]         fend_s;
      logic [3:0]         act_s;
      logic [15:0]        rdata;
      logic               irq;
      logic               gclk;
      logic [7:0]         gcnt;
      logic               started;
   } spcs_sys_t;

   typedef struct packed {
      spcs_pkg::spcs_lstate_t lstate;
      logic [4:0]             cnt;
      logic [RX_BITS-1:0]     rx_shift_reg;
      logic [RX_BITS-1:0]     word;
      logic [RX_BITS-1:0]     tsr;
      logic                   tx_act;
      logic                   dx;
      logic                   fs_prev;
      logic                   word_tg;
      logic                   err_tg;
      logic                   fss_tg;
      logic                   fend_tg;
      logic                   ack_tg;
      logic [3:0]             req_s;
      logic [2:0]             cfg_s0;
      logic [2:0]             cfg_s1;
      logic [2:0]             cfg_s2;
      logic [2:0]             cfg_u;
   } spcs_link_t;

   spcs_sys_t  s_q, s_d;
   spcs_link_t l_q, l_d;
   logic [1:0] rst_q;
   logic [1:0] lrst_q;
   logic       rst_n;
   logic       lrst_n;

   // Stage 0 only feeds stage 1; stage 3 keeps the last value on which 1 and 2 agreed.
   function automatic logic [3:0] sync_next(input logic [3:0] sv, input logic din);
      logic [3:0] r;
      r = {(sv[1] == sv[2]) ? sv[2] : sv[3], sv[1], sv[0], din};
      return r;
   endfunction

   function automatic logic sync_event(input logic [3:0] sv);
      return (sv[1] == sv[2]) && (sv[2] != sv[3]);
   endfunction

   function automatic logic [15:0] justify(input logic [RX_BITS-1:0] w, input logic [1:0] m);
      logic [15:0] r;
      r = 16'h0000;
      if (m == spcs_pkg::JUST_LEFT_ZERO)
      begin
         r[15 -: RX_BITS] = w;
      end
      else
      begin
         r[RX_BITS-1:0] = w;
         if (m == spcs_pkg::JUST_RIGHT_SIGN)
         begin
            for (int i = RX_BITS; i < 16; i++)
            begin
               r[i] = w[RX_BITS-1];
            end
         end
      end
      return r;
   endfunction

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rst_q <= 2'h0;
      else
         rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_n = rst_q[1];

   // The link clock may stop between frames, so its reset release waits for its own edges.
   always_ff @(posedge link_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         lrst_q <= 2'h0;
      else
         lrst_q <= {lrst_q[0], 1'b1};
   end
   assign lrst_n = lrst_q[1];

   logic       wr_sub, rd_sub, rx_on, tx_on, tx_rdy, alt_on, cstp_on;
   logic       word_ev, err_ev, fss_ev, fend_ev, serr_set;
   logic [1:0] irq_mode;

   always_comb
   begin
      s_d      = s_q;
      rx_on    = s_q.rx_ctrl[spcs_pkg::B_EN];
      tx_on    = s_q.tx_ctrl[spcs_pkg::B_EN];
      tx_rdy   = tx_on && (s_q.tx_req == s_q.ack_s[3]);
      alt_on   = s_q.rx_ctrl[spcs_pkg::B_ALT];
      irq_mode = s_q.rx_ctrl[spcs_pkg::B_IRQM_LO +: 2];
      cstp_on  = s_q.rx_ctrl[spcs_pkg::B_CSTP_HI];
      wr_sub   = bus_i.wr && (bus_i.addr == spcs_pkg::ADDR_SUB_DATA);
      rd_sub   = bus_i.rd && (bus_i.addr == spcs_pkg::ADDR_SUB_DATA);
      word_ev  = sync_event(s_q.word_s);
      err_ev   = sync_event(s_q.err_s);
      fss_ev   = sync_event(s_q.fss_s);
      fend_ev  = sync_event(s_q.fend_s);
      serr_set = 1'b0;
      s_d.ack_s  = sync_next(s_q.ack_s, l_q.ack_tg);
      s_d.word_s = sync_next(s_q.word_s, l_q.word_tg);
      s_d.err_s  = sync_next(s_q.err_s, l_q.err_tg);
      s_d.fss_s  = sync_next(s_q.fss_s, l_q.fss_tg);
      s_d.fend_s = sync_next(s_q.fend_s, l_q.fend_tg);
      s_d.act_s  = sync_next(s_q.act_s, l_q.lstate == spcs_pkg::SPCS_LS_SHIFT);

      // Register writes; of the flag bits outside the masks only the sync error bit is stored.
      if (bus_i.wr && (bus_i.addr == spcs_pkg::ADDR_SUB_SEL))
         s_d.sub_sel = bus_i.wdata;
      else if (wr_sub && (s_q.sub_sel == spcs_pkg::SUB_RX_CTRL))
      begin
         s_d.rx_ctrl = bus_i.wdata & spcs_pkg::RX_CTRL_RW_MASK;
         s_d.serr    = bus_i.wdata[spcs_pkg::B_SERR];
         serr_set    = bus_i.wdata[spcs_pkg::B_SERR] && !s_q.serr;
      end
      else if (wr_sub && (s_q.sub_sel == spcs_pkg::SUB_TX_CTRL))
         s_d.tx_ctrl = bus_i.wdata & spcs_pkg::TX_CTRL_RW_MASK;
      else if (bus_i.wr && (bus_i.addr == spcs_pkg::ADDR_TX_DATA) && tx_rdy)
      begin
         // A word written while the transmitter is busy or disabled is dropped.
         s_d.tx_data = bus_i.wdata;
         s_d.tx_req  = !s_q.tx_req;
      end

      // Reads answer one cycle later.
      if (bus_i.rd)
      begin
         if (bus_i.addr == spcs_pkg::ADDR_RX_DATA)
            s_d.rdata = s_q.rx_data;
         else if (bus_i.addr == spcs_pkg::ADDR_SUB_SEL)
            s_d.rdata = s_q.sub_sel;
         else if (rd_sub && (s_q.sub_sel == spcs_pkg::SUB_RX_CTRL))
            s_d.rdata = s_q.rx_ctrl | {12'h000, s_q.serr, s_q.ovr, s_q.rdy, 1'b0};
         else if (rd_sub && (s_q.sub_sel == spcs_pkg::SUB_TX_CTRL))
            s_d.rdata = s_q.tx_ctrl | {14'h0000, tx_rdy, 1'b0};
         else
            s_d.rdata = spcs_pkg::UNMAPPED_READ;
      end

      // Reading the data register frees it and pulls any buffered word forward.
      if (bus_i.rd && (bus_i.addr == spcs_pkg::ADDR_RX_DATA))
      begin
         s_d.rdy = 1'b0;
         s_d.ovr = 1'b0;
         if (s_q.buf_full)
         begin
            s_d.rx_data  = justify(s_q.rx_buf, s_q.rx_ctrl[spcs_pkg::B_JUST_LO +: 2]);
            s_d.rdy      = 1'b1;
            s_d.buf_full = 1'b0;
         end
      end
      if (word_ev && rx_on)
      begin
         if (!s_d.rdy)
         begin
            s_d.rx_data = justify(l_q.word, s_q.rx_ctrl[spcs_pkg::B_JUST_LO +: 2]);
            s_d.rdy     = 1'b1;
         end
         else if (!s_d.buf_full)
         begin
            s_d.rx_buf   = l_q.word;
            s_d.buf_full = 1'b1;
         end
         else
            s_d.ovr = 1'b1;
      end
      if (err_ev && rx_on)
      begin
         s_d.serr = 1'b1;
         serr_set = serr_set || !s_q.serr;
      end
      if (!rx_on && !s_d.rx_ctrl[spcs_pkg::B_EN])
      begin
         s_d.rdy      = 1'b0;
         s_d.ovr      = 1'b0;
         s_d.buf_full = 1'b0;
         s_d.serr     = 1'b0;
      end

      case (irq_mode)
         spcs_pkg::IRQ_WORD:  s_d.irq = rx_on && (word_ev || (alt_on && fend_ev));
         spcs_pkg::IRQ_FRAME: s_d.irq = rx_on && fend_ev;
         spcs_pkg::IRQ_FSYNC: s_d.irq = rx_on && fss_ev;
         default:             s_d.irq = serr_set;
      endcase

      // Transfer clock: free running, or gated by an active frame in clock-stop mode.
      s_d.gcnt = (s_q.gcnt == HALF_END) ? 8'h00 : s_q.gcnt + 8'h01;
      if (!cstp_on)
      begin
         s_d.started = 1'b0;
         if (s_q.gcnt == HALF_END)
            s_d.gclk = !s_q.gclk;
      end
      else if (!s_q.act_s[3])
      begin
         s_d.gclk    = tx_clock_polarity_i;
         s_d.gcnt    = 8'h00;
         s_d.started = 1'b0;
      end
      else if (!s_q.started &&
               (s_q.rx_ctrl[spcs_pkg::B_CSTP_LO +: 2] == spcs_pkg::CSTP_NO_DELAY))
      begin
         s_d.gclk    = !s_q.gclk;
         s_d.gcnt    = 8'h00;
         s_d.started = 1'b1;
      end
      else if (s_q.gcnt == HALF_END)
      begin
         s_d.gclk    = !s_q.gclk;
         s_d.started = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   logic fs_rise, rx_bit;

   always_comb
   begin
      l_d        = l_q;
      l_d.cfg_s0 = {s_q.rx_ctrl[spcs_pkg::B_LOOP], s_q.tx_ctrl[spcs_pkg::B_EN],
                    s_q.rx_ctrl[spcs_pkg::B_EN]};
      l_d.cfg_s1 = l_q.cfg_s0;
      l_d.cfg_s2 = l_q.cfg_s1;
      if (l_q.cfg_s1 == l_q.cfg_s2)
         l_d.cfg_u = l_q.cfg_s2;
      l_d.req_s   = sync_next(l_q.req_s, s_q.tx_req);
      l_d.fs_prev = fs_i;
      fs_rise     = fs_i && !l_q.fs_prev;
      // Loopback takes the bit being sent now, so the word returns without a one-bit lag.
      rx_bit      = l_q.cfg_u[spcs_pkg::CFG_LOOP] ? (l_q.tx_act && l_q.tsr[RX_BITS-1]) :
                    dr_i;
      if (!fs_i && l_q.fs_prev)
         l_d.fend_tg = !l_q.fend_tg;
      case (l_q.lstate)
         spcs_pkg::SPCS_LS_IDLE:
         begin
            l_d.dx = 1'b0;
            if (fs_rise && l_q.cfg_u[spcs_pkg::CFG_RX_ON])
            begin
               l_d.fss_tg = !l_q.fss_tg;
               l_d.lstate = spcs_pkg::SPCS_LS_SHIFT;
               l_d.cnt    = 5'h00;
               l_d.tx_act = l_q.cfg_u[spcs_pkg::CFG_TX_ON] && (l_q.req_s[3] != l_q.ack_tg);
               if (l_d.tx_act)
               begin
                  l_d.tsr    = s_q.tx_data[RX_BITS-1:0];
                  l_d.ack_tg = l_q.req_s[3];
               end
            end
         end
         spcs_pkg::SPCS_LS_SHIFT:
         begin
            l_d.rx_shift_reg = {l_q.rx_shift_reg[RX_BITS-2:0], rx_bit};
            l_d.cnt = l_q.cnt + 5'h01;
            l_d.dx  = l_q.tx_act && l_q.tsr[RX_BITS-1];
            l_d.tsr = {l_q.tsr[RX_BITS-2:0], 1'b0};
            if (fs_rise)
            begin
               // A sync inside a word aborts it and restarts the word.
               l_d.err_tg = !l_q.err_tg;
               l_d.fss_tg = !l_q.fss_tg;
               l_d.cnt    = 5'h00;
            end
            else if (l_q.cnt == LAST_BIT)
            begin
               l_d.word    = {l_q.rx_shift_reg[RX_BITS-2:0], rx_bit};
               l_d.word_tg = !l_q.word_tg;
               l_d.lstate  = spcs_pkg::SPCS_LS_IDLE;
            end
         end
         default:
            l_d.lstate = spcs_pkg::SPCS_LS_IDLE;
      endcase
      if (!l_q.cfg_u[spcs_pkg::CFG_RX_ON])
      begin
         l_d.lstate = spcs_pkg::SPCS_LS_IDLE;
         l_d.dx     = 1'b0;
      end
   end

   always_ff @(posedge link_clk_i or negedge lrst_n)
   begin
      if (!lrst_n)
         l_q <= '{lstate: spcs_pkg::SPCS_LS_IDLE, default: '0};
      else
         l_q <= l_d;
   end

   assign bus_rdata_o = s_q.rdata;
   assign rx_irq_o    = s_q.irq;
   assign xfer_clk_o  = s_q.gclk;
   assign dx_o        = l_q.dx;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_read_rx_ctrl;
      rd_sub && (s_q.sub_sel == spcs_pkg::SUB_RX_CTRL);
   endsequence
   sequence s_gate_begin;
      cstp_on && s_q.act_s[3] && !s_q.started;
   endsequence

   a_rsvd_reads_zero: assert property (s_read_rx_ctrl |=> bus_rdata_o[10:8] == 3'h0)
      else $error("reserved bits read nonzero");
   a_ovr_needs_full: assert property ($rose(s_q.ovr) |-> $past(s_q.buf_full && s_q.rdy))
      else $error("overrun without full buffer");
   a_rx_reset_holds: assert property (!rx_on ##1 !rx_on |-> !s_q.rdy && !s_q.ovr)
      else $error("flags alive in receiver reset");
   a_irq_on_fsync: assert property (rx_on && irq_mode == spcs_pkg::IRQ_FSYNC && fss_ev
                                    |=> rx_irq_o)
      else $error("frame sync irq missing");
   a_irq_on_serr: assert property (irq_mode == spcs_pkg::IRQ_SYNC_ERR && $rose(s_q.serr)
                                   |-> rx_irq_o)
      else $error("sync error irq missing");
   a_tx_ready_drop: assert property (bus_i.wr && bus_i.addr == spcs_pkg::ADDR_TX_DATA && tx_rdy
                                     |=> !tx_rdy)
      else $error("transmit ready stayed high");
   a_gate_no_delay: assert property (s_gate_begin and
                    (s_q.rx_ctrl[spcs_pkg::B_CSTP_LO +: 2] == spcs_pkg::CSTP_NO_DELAY)
                    |=> xfer_clk_o != tx_clock_polarity_i)
      else $error("gated clock late");
   a_gate_delayed: assert property (s_gate_begin and s_q.gcnt == 8'h00 and
                   (s_q.rx_ctrl[spcs_pkg::B_CSTP_LO +: 2] == spcs_pkg::CSTP_HALF_DELAY)
                   |=> xfer_clk_o == tx_clock_polarity_i)
      else $error("gated clock early");
   a_ready_clears: assert property (bus_i.rd && bus_i.addr == spcs_pkg::ADDR_RX_DATA &&
                   !s_q.buf_full && !word_ev |=> !s_q.rdy)
      else $error("ready not cleared by read");
endmodule

// file: tb/spcs_codec_model.sv
// Behavioural model of the serial codec that drives frame sync and receive data.
module spcs_codec_model (
   input  wire logic link_clk_i,
   output logic      fs_o,
   output logic      dr_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      fs_o = 1'b0;
      dr_o = 1'b0;
   end

   // Sends a one-cycle frame sync, then the word MSB first; a cut below 8 stops the word early.
   task automatic send_word(input logic [7:0] w, input int cut);
      int i;
      @(posedge link_clk_i);
      #1;
      fs_o = 1'b1;
      @(posedge link_clk_i);
      #1;
      fs_o = 1'b0;
      for (i = 7; i >= 8 - cut; i--)
      begin
         dr_o = w[i];
         @(posedge link_clk_i);
         #1;
      end
      // The line is inverted after the word, so the last bit must not linger.
      dr_o = ~dr_o;
   endtask
endmodule

// file: tb/serial_port_control_status_tb.sv
// Self-checking testbench for the serial port control and status block.
module serial_port_control_status_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic                    clk_i;
   logic                    nrst_i;
   logic                    link_clk_i;
   spcs_pkg::spcs_bus_req_t bus_q;
   logic [15:0]             bus_rdata_o;
   logic                    rx_irq_o;
   logic                    xfer_clk_o;
   logic                    pol_q;
   logic                    dr_i;
   logic                    fs_i;
   logic                    dx_o;
   logic [15:0]             v;
   logic [1:0]              k;
   logic                    lvl;
   int                      fails = 0;
   int                      check_count = 0;
   int                      irq_cnt = 0;
   int                      n;
   int                      ch;
   logic [15:0]             just_exp [3] = '{16'h00A5, 16'hFFA5, 16'hA500};
   logic [15:0]             irq_exp [5] = '{16'h0001, 16'h0001, 16'h0001, 16'h0000, 16'h0002};

   spcs_serial_port spcs_serial_port_i (
      .clk_i               (clk_i),
      .nrst_i              (nrst_i),
      .bus_i               (bus_q),
      .bus_rdata_o         (bus_rdata_o),
      .rx_irq_o            (rx_irq_o),
      .xfer_clk_o          (xfer_clk_o),
      .tx_clock_polarity_i (pol_q),
      .link_clk_i          (link_clk_i),
      .dr_i                (dr_i),
      .fs_i                (fs_i),
      .dx_o                (dx_o)
   );

   spcs_codec_model spcs_codec_model_i (
      .link_clk_i (link_clk_i),
      .fs_o       (fs_i),
      .dr_o       (dr_i)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // The link clock runs continuously, as clock-stop is off in normal clocking.
   initial
   begin
      link_clk_i = 1'b0;
      #7;
      forever #32 link_clk_i = ~link_clk_i;
   end

   always @(posedge clk_i)
      if (rx_irq_o === 1'b1)
         irq_cnt <= irq_cnt + 1;

   task automatic close_out();
      $display("Counts: %0d comparisons, %0d mismatches", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         fails++;
      end
   endtask

   task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk_i);
      bus_q <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
      @(posedge clk_i);
      bus_q.wr <= 1'b0;
   endtask

   // Read data is registered and holds until the next read, so one idle edge is safe.
   task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge clk_i);
      bus_q <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
      @(posedge clk_i);
      bus_q.rd <= 1'b0;
      @(posedge clk_i);
      d = bus_rdata_o;
   endtask

   task automatic wr_sub(input logic [15:0] s, input logic [15:0] d);
      bus_wr(spcs_pkg::ADDR_SUB_SEL, s);
      bus_wr(spcs_pkg::ADDR_SUB_DATA, d);
   endtask

   task automatic rd_sub(input logic [15:0] s, output logic [15:0] d);
      bus_wr(spcs_pkg::ADDR_SUB_SEL, s);
      bus_rd(spcs_pkg::ADDR_SUB_DATA, d);
   endtask

   // The link side sees a new setting only after its synchroniser has settled.
   task automatic link_settle();
      repeat (5) @(posedge link_clk_i);
   endtask

   task automatic wait_flag(input int pos);
      logic [15:0] r;
      int          i;
      for (i = 0; i < 100; i++)
      begin
         rd_sub(spcs_pkg::SUB_RX_CTRL, r);
         if (r[pos] === 1'b1)
            return;
      end
      $display("wrong value at %0t: flag bit %0d never set", $time, pos);
      fails++;
      close_out();
   endtask

   task automatic clk_watch(output int c, output logic l);
      logic prev;
      int   i;
      repeat (12) @(posedge clk_i);
      prev = xfer_clk_o;
      c = 0;
      for (i = 0; i < 24; i++)
      begin
         @(posedge clk_i);
         if (xfer_clk_o !== prev)
            c++;
         prev = xfer_clk_o;
      end
      l = xfer_clk_o;
   endtask

   initial
   begin
      #200000;
      $display("wrong value at %0t: run did not finish", $time);
      fails++;
      close_out();
   end

   initial
   begin
      nrst_i = 1'b0;
      bus_q = '0;
      pol_q = 1'b0;
      // Reset spans two link edges so that the link domain is cleared too.
      repeat (40) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd_sub(spcs_pkg::SUB_RX_CTRL, v); check(v, 16'h0000);
      rd_sub(spcs_pkg::SUB_TX_CTRL, v); check(v, 16'h0000);
      bus_rd(16'h0050, v); check(v, 16'h0000);
      // The error interrupt mode is set first, so the forced error meets it.
      wr_sub(spcs_pkg::SUB_RX_CTRL, 16'hFFF7);
      n = irq_cnt;
      wr_sub(spcs_pkg::SUB_RX_CTRL, 16'hFFFF);
      rd_sub(spcs_pkg::SUB_RX_CTRL, v); check(v, 16'hF8F9);
      check(16'(irq_cnt - n), 16'h0001);
      wr_sub(spcs_pkg::SUB_RX_CTRL, 16'h0000);
      rd_sub(spcs_pkg::SUB_RX_CTRL, v); check(v, 16'h0000);
      wr_sub(spcs_pkg::SUB_TX_CTRL, 16'hFFFF);
      rd_sub(spcs_pkg::SUB_TX_CTRL, v); check(v, 16'h03FB);
      wr_sub(spcs_pkg::SUB_TX_CTRL, 16'h0000);
      rd_sub(spcs_pkg::SUB_TX_CTRL, v); check(v, 16'h0000);
      spcs_codec_model_i.send_word(8'hA5, 8);
      rd_sub(spcs_pkg::SUB_RX_CTRL, v); check(v, 16'h0000);
      $display("Test of register access done.");
      for (int j = 0; j < 3; j++)
      begin
         k = 2'(j);
         wr_sub(spcs_pkg::SUB_RX_CTRL, {1'b0, k, 13'h0001});
         link_settle();
         spcs_codec_model_i.send_word(8'hA5, 8);
         wait_flag(spcs_pkg::B_RDY);
         bus_rd(spcs_pkg::ADDR_RX_DATA, v); check(v, just_exp[j]);
         rd_sub(spcs_pkg::SUB_RX_CTRL, v); check(v, {1'b0, k, 13'h0001});
         wr_sub(spcs_pkg::SUB_RX_CTRL, 16'h0000);
      end
      $display("Test of justification done.");
      for (int j = 0; j < 5; j++)
      begin
         k = 2'(j);
         wr_sub(spcs_pkg::SUB_RX_CTRL, {9'h000, j == 4, k, 4'h1});
         link_settle();
         n = irq_cnt;
         spcs_codec_model_i.send_word(8'h3C, 8);
         wait_flag(spcs_pkg::B_RDY);
         check(16'(irq_cnt - n), irq_exp[j]);
         bus_rd(spcs_pkg::ADDR_RX_DATA, v);
         wr_sub(spcs_pkg::SUB_RX_CTRL, 16'h0000);
      end
      $display("Test of interrupt modes done.");
      wr_sub(spcs_pkg::SUB_RX_CTRL, 16'h0031);
      link_settle();
      n = irq_cnt;
      spcs_codec_model_i.send_word(8'hFF, 3);
      spcs_codec_model_i.send_word(8'h5A, 8);
      wait_flag(spcs_pkg::B_RDY);
      rd_sub(spcs_pkg::SUB_RX_CTRL, v); check(v, 16'h003B);
      check(16'(irq_cnt - n), 16'h0001);
      bus_rd(spcs_pkg::ADDR_RX_DATA, v); check(v, 16'h005A);
      wr_sub(spcs_pkg::SUB_RX_CTRL, 16'h0000);
      $display("Test of sync error done.");
      wr_sub(spcs_pkg::SUB_RX_CTRL, 16'h0001);
      link_settle();
      spcs_codec_model_i.send_word(8'h11, 8);
      spcs_codec_model_i.send_word(8'h22, 8);
      spcs_codec_model_i.send_word(8'h33, 8);
      wait_flag(spcs_pkg::B_OVR);
      rd_sub(spcs_pkg::SUB_RX_CTRL, v); check(v, 16'h0007);
      bus_rd(spcs_pkg::ADDR_RX_DATA, v); check(v, 16'h0011);
      wait_flag(spcs_pkg::B_RDY);
      rd_sub(spcs_pkg::SUB_RX_CTRL, v); check(v, 16'h0003);
      bus_rd(spcs_pkg::ADDR_RX_DATA, v); check(v, 16'h0022);
      rd_sub(spcs_pkg::SUB_RX_CTRL, v); check(v, 16'h0001);
      wr_sub(spcs_pkg::SUB_RX_CTRL, 16'h0000);
      $display("Test of overrun done.");
      wr_sub(spcs_pkg::SUB_TX_CTRL, 16'h0001);
      wr_sub(spcs_pkg::SUB_RX_CTRL, 16'h8001);
      bus_wr(spcs_pkg::ADDR_TX_DATA, 16'h003C);
      link_settle();
      spcs_codec_model_i.send_word(8'h00, 8);
      wait_flag(spcs_pkg::B_RDY);
      bus_rd(spcs_pkg::ADDR_RX_DATA, v); check(v, 16'h003C);
      wr_sub(spcs_pkg::SUB_TX_CTRL, 16'h0000);
      wr_sub(spcs_pkg::SUB_RX_CTRL, 16'h0000);
      $display("Test of loopback done.");
      for (int j = 0; j < 4; j++)
      begin
         k = 2'(j);
         pol_q <= k[0];
         wr_sub(spcs_pkg::SUB_RX_CTRL, {3'b000, 1'b1, k[1], 10'h000, 1'b1});
         clk_watch(ch, lvl);
         check({15'h0000, lvl}, {15'h0000, k[0]});
         check(16'(ch), 16'h0000);
         link_settle();
         spcs_codec_model_i.send_word(8'h5A, 8);
         wait_flag(spcs_pkg::B_RDY);
         bus_rd(spcs_pkg::ADDR_RX_DATA, v); check(v, 16'h005A);
      end
      wr_sub(spcs_pkg::SUB_RX_CTRL, 16'h0000);
      clk_watch(ch, lvl);
      check(16'(ch > 0), 16'h0001);
      $display("Test of clock stop done.");
      close_out();
   end
endmodule
